// file: core/rir_defines.svh
// constants for the return-from-interrupt and rotate-left execution block
`ifndef RIR_DEFINES_SVH
`define RIR_DEFINES_SVH

`define RIR_PC_W 12
`define RIR_DATA_W 8
`define RIR_DATA_MSB 7
`define RIR_ADDR_W 8
`define RIR_STACK_DEPTH 8
`define RIR_SP_W 3
`define RIR_SP_RST 3'h0
`define RIR_PC_RST 12'h000
`define RIR_DATA_RST 8'h00
`define RIR_ADDR_RST 8'h00
`define RIR_MIE_RST 1'b0
`define RIR_MIE_ON 1'b1
`define RIR_MIE_OFF 1'b0

`endif

// file: core/rir_exec.sv
// execution of return-from-interrupt and rotate-left for the 8-bit core
`timescale 1ns/10ps
`include "rir_defines.svh"

module rir_exec
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire rir_pkg::rir_op_t op_in,
	input wire logic [`RIR_ADDR_W-1:0] addr_in,
	input wire logic pc_load_in,
	input wire logic [`RIR_PC_W-1:0] pc_value_in,
	input wire logic push_in,
	input wire logic [`RIR_PC_W-1:0] push_data_in,
	input wire logic mie_clear_in,
	input wire logic irq_pending_in,
	input wire logic [`RIR_PC_W-1:0] irq_vector_in,
	input wire logic [`RIR_DATA_W-1:0] dm_rdata_in,
	output logic busy_out,
	output logic done_out,
	output logic [`RIR_PC_W-1:0] pc_out,
	output logic master_interrupt_enable_out,
	output logic irq_ack_out,
	output logic stack_empty_out,
	output logic [`RIR_ADDR_W-1:0] dm_addr_out,
	output logic dm_rd_out,
	output logic dm_wr_out,
	output logic [`RIR_DATA_W-1:0] dm_wdata_out
);
	import rir_pkg::*;

	rir_regs_t r;
	rir_regs_t next_r;
	logic idle_start;
	logic stk_push;
	logic stk_pop;
	logic [`RIR_PC_W-1:0] stk_wdata;
	logic [`RIR_PC_W-1:0] stk_top;

	function automatic logic [`RIR_DATA_W-1:0] rotl(input logic [`RIR_DATA_W-1:0] v);
		rotl = {v[`RIR_DATA_MSB-1:0], v[`RIR_DATA_MSB]};
	endfunction

	assign idle_start = start_in && (r.st == st_idle);

	// pop is issued in the start cycle so the stack's registered top is ready in st_pop
	assign stk_pop = idle_start && (op_in == op_return_from_interrupt);
	// vectoring saves the restored address, so the main program resumes there later
	assign stk_push = (r.st == st_irq) || (push_in && (r.st == st_idle) && !stk_pop);
	assign stk_wdata = (r.st == st_irq) ? r.pc : push_data_in;

	rir_stack u_stack
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.push_in(stk_push),
		.pop_in(stk_pop),
		.push_data_in(stk_wdata),
		.top_out(stk_top),
		.empty_out(stack_empty_out)
	);

	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.ack = 1'b0;
		next_r.rd = 1'b0;
		next_r.wr = 1'b0;
		// a clear from the interrupt controller loses against the set below
		if (mie_clear_in)
		begin
			next_r.mie = `RIR_MIE_OFF;
		end
		if (pc_load_in && (r.st == st_idle))
		begin
			next_r.pc = pc_value_in;
		end
		case (r.st)
			st_idle:
			begin
				if (start_in)
				begin
					if (op_in == op_return_from_interrupt)
					begin
						next_r.st = st_pop;
					end
					else
					begin
						next_r.addr = addr_in;
						next_r.rd = 1'b1;
						next_r.st = st_rlr;
					end
				end
			end
			st_pop:
			begin
				next_r.pc = stk_top;
				next_r.mie = `RIR_MIE_ON;
				if (irq_pending_in)
				begin
					next_r.st = st_irq;
				end
				else
				begin
					next_r.done = 1'b1;
					next_r.st = st_idle;
				end
			end
			st_irq:
			begin
				// entering the handler masks further interrupts as a normal entry does
				next_r.pc = irq_vector_in;
				next_r.mie = `RIR_MIE_OFF;
				next_r.ack = 1'b1;
				next_r.done = 1'b1;
				next_r.st = st_idle;
			end
			st_rlr:
			begin
				next_r.st = st_rld;
			end
			st_rld:
			begin
				// address held from the read; no flag output exists to disturb
				next_r.wdata = rotl(dm_rdata_in);
				next_r.wr = 1'b1;
				next_r.done = 1'b1;
				next_r.st = st_idle;
			end
			default:
			begin
				next_r.st = st_idle;
			end
		endcase
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			r.st <= st_idle;
			r.pc <= `RIR_PC_RST;
			r.mie <= `RIR_MIE_RST;
			r.addr <= `RIR_ADDR_RST;
			r.rd <= 1'b0;
			r.wr <= 1'b0;
			r.wdata <= `RIR_DATA_RST;
			r.done <= 1'b0;
			r.ack <= 1'b0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign busy_out = (r.st != st_idle);
	assign done_out = r.done;
	assign pc_out = r.pc;
	assign master_interrupt_enable_out = r.mie;
	assign irq_ack_out = r.ack;
	assign dm_addr_out = r.addr;
	assign dm_rd_out = r.rd;
	assign dm_wr_out = r.wr;
	assign dm_wdata_out = r.wdata;

	property p_return_from_interrupt_op_pc;
		@(posedge clock_in) disable iff (rst_in)
		(r.st == st_pop) |=> (pc_out == $past(stk_top));
	endproperty
	a_return_from_interrupt_op_pc: assert property (p_return_from_interrupt_op_pc) else $error("pc not restored from stack");

	property p_return_from_interrupt_op_pop;
		@(posedge clock_in) disable iff (rst_in)
		(start_in && !busy_out && op_in == op_return_from_interrupt) |=> (r.st == st_pop);
	endproperty
	a_return_from_interrupt_op_pop: assert property (p_return_from_interrupt_op_pop) else $error("return did not pop");

	property p_return_from_interrupt_op_mie;
		@(posedge clock_in) disable iff (rst_in)
		(r.st == st_pop) |=> master_interrupt_enable_out;
	endproperty
	a_return_from_interrupt_op_mie: assert property (p_return_from_interrupt_op_mie) else $error("enable not set by return");

	property p_return_from_interrupt_op_irq;
		@(posedge clock_in) disable iff (rst_in)
		(r.st == st_pop && irq_pending_in) |=> ##1 (irq_ack_out && pc_out == $past(irq_vector_in));
	endproperty
	a_return_from_interrupt_op_irq: assert property (p_return_from_interrupt_op_irq) else $error("pending interrupt not taken");

	property p_return_from_interrupt_op_nopend;
		@(posedge clock_in) disable iff (rst_in)
		(r.st == st_pop && !irq_pending_in) |=> (done_out && !irq_ack_out);
	endproperty
	a_return_from_interrupt_op_nopend: assert property (p_return_from_interrupt_op_nopend) else $error("spurious vectoring");

	property p_rl_data;
		@(posedge clock_in) disable iff (rst_in)
		(r.st == st_rld) |=> (dm_wr_out
			&& dm_wdata_out[0] == $past(dm_rdata_in[`RIR_DATA_MSB])
			&& dm_wdata_out[`RIR_DATA_MSB:1] == $past(dm_rdata_in[`RIR_DATA_MSB-1:0]));
	endproperty
	a_rl_data: assert property (p_rl_data) else $error("rotate result wrong");

	property p_rl_addr;
		@(posedge clock_in) disable iff (rst_in)
		dm_rd_out |=> ##1 (dm_wr_out && dm_addr_out == $past(dm_addr_out, 2));
	endproperty
	a_rl_addr: assert property (p_rl_addr) else $error("rotate wrote another address");

	// the read address must be the one given with the start, not a stale one
	property p_rl_start;
		@(posedge clock_in) disable iff (rst_in)
		(start_in && !busy_out && op_in == op_rotate_left) |=> (dm_rd_out && dm_addr_out == $past(addr_in));
	endproperty
	a_rl_start: assert property (p_rl_start) else $error("rotate read wrong address");

	property p_irq_entry;
		@(posedge clock_in) disable iff (rst_in)
		(r.st == st_irq) |=> (!master_interrupt_enable_out && done_out && !busy_out);
	endproperty
	a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry incomplete");
endmodule

// file: core/rir_pkg.sv
// types shared by the execution block and its stack memory
`include "rir_defines.svh"

package rir_pkg;

	typedef enum logic [0:0]
	{
		op_return_from_interrupt = 1'b0,
		op_rotate_left = 1'b1
	} rir_op_t;

	// gray along both paths: idle-pop-irq and idle-rlr-rld
	typedef enum logic [2:0]
	{
		st_idle = 3'h0,
		st_pop = 3'h1,
		st_irq = 3'h3,
		st_rlr = 3'h4,
		st_rld = 3'h6
	} rir_state_t;

	typedef struct packed
	{
		rir_state_t st;
		logic [`RIR_PC_W-1:0] pc;
		logic mie;
		logic [`RIR_ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic [`RIR_DATA_W-1:0] wdata;
		logic done;
		logic ack;
	} rir_regs_t;

	typedef struct packed
	{
		logic [`RIR_STACK_DEPTH-1:0][`RIR_PC_W-1:0] mem;
		logic [`RIR_SP_W-1:0] sp;
		logic [`RIR_PC_W-1:0] top;
	} rir_stack_t;

endpackage

// file: core/rir_stack.sv
// hardware return-address stack with registered pop data
`timescale 1ns/10ps
`include "rir_defines.svh"

module rir_stack
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [`RIR_PC_W-1:0] push_data_in,
	output logic [`RIR_PC_W-1:0] top_out,
	output logic empty_out
);
	import rir_pkg::*;

	rir_stack_t s;
	rir_stack_t next_s;

	// the pointer wraps: overflow silently overwrites the oldest entry
	always_comb
	begin
		next_s = s;
		if (push_in)
		begin
			next_s.mem[s.sp] = push_data_in;
			next_s.sp = `RIR_SP_W'(s.sp + 1'b1);
		end
		else if (pop_in)
		begin
			next_s.sp = `RIR_SP_W'(s.sp - 1'b1);
			next_s.top = s.mem[`RIR_SP_W'(s.sp - 1'b1)];
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign top_out = s.top;
	assign empty_out = (s.sp == `RIR_SP_RST);
endmodule

// file: test/tb_rir_exec.sv
// self-checking testbench for the return-from-interrupt and rotate-left block
`timescale 1ns/10ps
`include "rir_defines.svh"
module tb_rir_exec;
	import rir_pkg::*;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic start_in = 1'b0;
	rir_op_t op_in = op_return_from_interrupt;
	logic [7:0] addr_in = 8'h00;
	logic pc_load_in = 1'b0;
	logic [11:0] pc_value_in = 12'h000;
	logic push_in = 1'b0;
	logic [11:0] push_data_in = 12'h000;
	logic mie_clear_in = 1'b0;
	logic irq_pending_in = 1'b0;
	logic [11:0] irq_vector_in = 12'h000;
	logic [7:0] dm_rdata_in = 8'hFF;
	logic busy_out, done_out, mie_out, irq_ack_out, empty_out, dm_rd_out, dm_wr_out;
	logic [11:0] pc_out;
	logic [7:0] dm_addr_out, dm_wdata_out;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	rir_exec i_dut (.clock_in(clock_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
		.addr_in(addr_in), .pc_load_in(pc_load_in), .pc_value_in(pc_value_in),
		.push_in(push_in), .push_data_in(push_data_in), .mie_clear_in(mie_clear_in),
		.irq_pending_in(irq_pending_in), .irq_vector_in(irq_vector_in),
		.dm_rdata_in(dm_rdata_in), .busy_out(busy_out), .done_out(done_out), .pc_out(pc_out),
		.master_interrupt_enable_out(mie_out), .irq_ack_out(irq_ack_out),
		.stack_empty_out(empty_out), .dm_addr_out(dm_addr_out), .dm_rd_out(dm_rd_out),
		.dm_wr_out(dm_wr_out), .dm_wdata_out(dm_wdata_out));
	always #50 clock_in = ~clock_in;
	task step();
		@(negedge clock_in);
	endtask
	task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task start_op(input rir_op_t op, input logic [7:0] a);
		op_in = op;
		addr_in = a;
		start_in = 1'b1;
		step();
		start_in = 1'b0;
	endtask
	task push(input logic [11:0] d);
		push_data_in = d;
		push_in = 1'b1;
		step();
		push_in = 1'b0;
		// let an edge pass so a following push raises the strobe in a new step
		step();
	endtask
	task t_reset();
		chk("pc", 12'h000, pc_out);
		chk("mie", 12'h000, {11'h000, mie_out});
		chk("empty", 12'h001, {11'h000, empty_out});
		pc_load_in = 1'b1;
		pc_value_in = 12'h3A5;
		step();
		pc_load_in = 1'b0;
		chk("pc load", 12'h3A5, pc_out);
		$display("test reset done");
	endtask
	task t_return();
		push(12'h123);
		push(12'h456);
		// clear stays high through the pop cycle so it meets the set there
		mie_clear_in = 1'b1;
		start_op(op_return_from_interrupt, 8'h00);
		chk("busy", 12'h001, {11'h000, busy_out});
		step();
		mie_clear_in = 1'b0;
		chk("done", 12'h001, {11'h000, done_out});
		chk("pc", 12'h456, pc_out);
		chk("mie", 12'h001, {11'h000, mie_out});
		start_op(op_return_from_interrupt, 8'h00);
		chk("done", 12'h000, {11'h000, done_out});
		step();
		chk("pc", 12'h123, pc_out);
		chk("empty", 12'h001, {11'h000, empty_out});
		mie_clear_in = 1'b1;
		step();
		mie_clear_in = 1'b0;
		chk("mie", 12'h000, {11'h000, mie_out});
		$display("test return done");
	endtask
	task t_pending();
		push(12'h2B7);
		irq_vector_in = 12'h0F0;
		irq_pending_in = 1'b1;
		start_op(op_return_from_interrupt, 8'h00);
		step();
		chk("pc", 12'h2B7, pc_out);
		chk("mie", 12'h001, {11'h000, mie_out});
		step();
		irq_pending_in = 1'b0;
		chk("ack", 12'h001, {11'h000, irq_ack_out});
		chk("done", 12'h001, {11'h000, done_out});
		chk("vector pc", 12'h0F0, pc_out);
		chk("mie masked", 12'h000, {11'h000, mie_out});
		start_op(op_return_from_interrupt, 8'h00);
		step();
		chk("resume pc", 12'h2B7, pc_out);
		chk("ack", 12'h000, {11'h000, irq_ack_out});
		$display("test pending done");
	endtask
	task t_rotate();
		logic [7:0] v;
		logic [7:0] a;
		static logic [7:0] tbl [5] = '{8'h81, 8'h40, 8'h5A, 8'hFF, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			v = tbl[i];
			a = 8'hC0 + 8'(i);
			start_op(op_rotate_left, a);
			chk("rd", 12'h001, {11'h000, dm_rd_out});
			chk("rd addr", {4'h0, a}, {4'h0, dm_addr_out});
			step();
			dm_rdata_in = v;
			// pc load and push while busy must be ignored
			pc_load_in = 1'b1;
			push_in = 1'b1;
			step();
			dm_rdata_in = ~v;
			pc_load_in = 1'b0;
			push_in = 1'b0;
			chk("empty kept", 12'h001, {11'h000, empty_out});
			chk("wr", 12'h001, {11'h000, dm_wr_out});
			chk("wdata", {4'h0, v[6:0], v[7]}, {4'h0, dm_wdata_out});
			chk("wr addr", {4'h0, a}, {4'h0, dm_addr_out});
			chk("done", 12'h001, {11'h000, done_out});
			chk("pc kept", 12'h2B7, pc_out);
		end
		$display("test rotate done");
	endtask
	task complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// generous ceiling, the whole sequence needs well under a hundred cycles
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			complete_run();
		end
	end
	initial
	begin
		repeat (10) step();
		rst_in = 1'b0;
		t_reset();
		t_return();
		t_pending();
		t_rotate();
		complete_run();
	end
endmodule
